// ### mdac_muldiv_accel.v
// Notes on behaviour
// - unsigned multiply, divide, shift, normalise only
// - 32/16 divide ready after 17 cycles
// - 16/16 divide ready after 9 cycles
// - 16x16 multiply ready after 9 cycles
// - divide load order, byte0 resets, last starts
// - divide read order ends at control read
// - multiply load and read order
// - zero shift count means normalise, count returned
// - normalise left, result back, control write starts
// - nonzero count shifts exactly that many places
// - direction one right, zero left, result stored
// - shift result replaces bytes 0 to 3
// - error tracking from byte0 write to last read
// - operand write while busy sets error
// - control read clears error flag
// - overflow on zero divisor, big product, normalised
`include "mdac_regs.vh"
`default_nettype none
module mdac_muldiv_accel #(
  parameter integer LAT_MUL = `MDAC_LAT_MUL
) (
  // clock and reset
  input wire core_clk_i,
  input wire resetn_i,
  // ahb-lite slave
  input wire hsel_i,
  input wire [31:0] haddr_i,
  input wire [1:0] htrans_i,
  input wire hwrite_i,
  input wire [2:0] hsize_i,
  input wire [31:0] hwdata_i,
  input wire hready_i,
  output reg [31:0] hrdata_o,
  output reg hreadyout_o,
  output reg hresp_o,
  // interrupt
  output reg irq_o
);
  // =====================================================
  // reset release
  reg rst_s1_r;
  reg rst_n_r;
  // two-stage release keeps reset removal synchronous
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // =====================================================
  // helpers
  function [31:0] byte_addr;
    input [7:0] idx;
    begin
      byte_addr = {22'd0, idx, 2'b00};
    end
  endfunction

  // =====================================================
  // ahb address phase capture
  reg wr_pend_r;
  reg [7:0] wr_idx_r;
  reg [7:0] rd_idx;
  reg [7:0] idx_c;
  wire take = hsel_i && hready_i && htrans_i[1];
  wire addr_ok = (haddr_i[31:10] == 22'd0) && (haddr_i[1:0] == 2'b00);
  always @* begin
    idx_c = addr_ok ? haddr_i[9:2] : 8'h00;
    rd_idx = (take && !hwrite_i) ? idx_c : 8'h00;
  end
  wire rd_now = take && !hwrite_i;
  // ready stays high through reset as well, so requests made before the
  // two-edge release are dropped: software must wait that out
  // writes land in the data phase, one cycle after the address
  always @(posedge core_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 8'h00;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end else begin
      wr_pend_r <= take && hwrite_i;
      wr_idx_r <= idx_c;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
    end
  end
  wire [7:0] wdat = hwdata_i[7:0];
  wire wr_op0 = wr_pend_r && wr_idx_r == `MDAC_IDX_OP0;
  wire wr_op1 = wr_pend_r && wr_idx_r == `MDAC_IDX_OP1;
  wire wr_op2 = wr_pend_r && wr_idx_r == `MDAC_IDX_OP2;
  wire wr_op3 = wr_pend_r && wr_idx_r == `MDAC_IDX_OP3;
  wire wr_op4 = wr_pend_r && wr_idx_r == `MDAC_IDX_OP4;
  wire wr_op5 = wr_pend_r && wr_idx_r == `MDAC_IDX_OP5;
  wire wr_arc = wr_pend_r && wr_idx_r == `MDAC_IDX_ARC;
  wire wr_any_op = wr_op0 | wr_op1 | wr_op2 | wr_op3 | wr_op4 | wr_op5;
  wire rd_arc = rd_now && rd_idx == `MDAC_IDX_ARC;

  // =====================================================
  // load sequence tracking
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_MUL = 3'd1;
  localparam [2:0] S_DIV = 3'd2;
  localparam [2:0] S_SHF = 3'd3;
  localparam [2:0] S_DONE = 3'd4;
  reg [2:0] st_r;
  reg [5:0] wmask_r; // which operand bytes have been written since byte0
  reg mul_ord_r; // byte1 arrived after byte4: the multiply load order
  reg [7:0] op_r [0:5];
  reg [7:0] arc_r;
  reg err_r;
  reg ovf_r;
  reg [4:0] mcnt_r;
  reg wide_r;
  reg [31:0] prod_r;
  wire busy = (st_r == S_MUL) || (st_r == S_DIV) || (st_r == S_SHF);
  // order of writes picks the operation: 4 then 1 then 5 is multiply;
  // the plain byte mask cannot tell this from a short divide (0,1,4,5)
  wire start_mul = wr_op5 && mul_ord_r && !wmask_r[2];
  wire start_div = wr_op5 && !start_mul;
  wire start_shf = wr_arc;
  wire div_wide = wmask_r[2] | wmask_r[3];
  wire [31:0] dvd = {op_r[3], op_r[2], op_r[1], op_r[0]};
  wire [15:0] dvs = {op_r[5], op_r[4]};

  wire div_busy;
  wire [31:0] div_q;
  wire [15:0] div_rem;
  wire shf_busy;
  wire [31:0] shf_val;
  wire [4:0] shf_cnt;
  // both engines latch their operands at start: the bus bytes move on
  // divider engine
  mdac_divider u_div (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_r),
    .start_i(start_div),
    .wide_i(div_wide),
    .dividend_i(dvd),
    .divisor_i({wdat, op_r[4]}),
    .busy_o(div_busy),
    .quot_o(div_q),
    .rem_o(div_rem)
  );
  mdac_shifter u_shf (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_r),
    .start_i(start_shf),
    .norm_i(wdat[4:0] == 5'd0),
    .right_i(wdat[`MDAC_ARC_DIR]),
    .count_i(wdat[4:0]),
    .value_i(dvd),
    .busy_o(shf_busy),
    .value_o(shf_val),
    .shifts_o(shf_cnt)
  );

  // =====================================================
  // operation state and operand registers
  integer i;
  reg done_ev;
  reg err_ev;
  reg ovf_ev;
  always @(posedge core_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      st_r <= S_IDLE;
      wmask_r <= 6'd0;
      mul_ord_r <= 1'b0;
      arc_r <= `MDAC_ARC_RST;
      err_r <= 1'b0;
      ovf_r <= 1'b0;
      mcnt_r <= 5'd0;
      wide_r <= 1'b0;
      prod_r <= 32'h0000_0000;
      done_ev <= 1'b0;
      err_ev <= 1'b0;
      ovf_ev <= 1'b0;
      for (i = 0; i < 6; i = i + 1) begin
        op_r[i] <= 8'h00;
      end
    end else begin
      done_ev <= 1'b0;
      err_ev <= 1'b0;
      ovf_ev <= 1'b0;
      if (rd_arc) begin
        err_r <= 1'b0;
      end
      if (wr_any_op && busy) begin
        err_r <= 1'b1;
        err_ev <= 1'b1;
      end
      if (wr_op0) begin
        wmask_r <= 6'b00_0001;
        mul_ord_r <= 1'b0;
        st_r <= S_IDLE;
        ovf_r <= 1'b0;
      end else if (wr_any_op) begin
        wmask_r <= wmask_r | {wr_op5, wr_op4, wr_op3, wr_op2, wr_op1, 1'b0};
        // the order is judged when byte1 lands
        if (wr_op1) begin
          mul_ord_r <= wmask_r[4];
        end
      end
      if (wr_op0) op_r[0] <= wdat;
      if (wr_op1) op_r[1] <= wdat;
      if (wr_op2) op_r[2] <= wdat;
      if (wr_op3) op_r[3] <= wdat;
      if (wr_op4) op_r[4] <= wdat;
      if (wr_op5) op_r[5] <= wdat;
      if (wr_arc) begin
        arc_r[5:0] <= wdat[5:0];
      end
      if (start_mul) begin
        st_r <= S_MUL;
        mcnt_r <= LAT_MUL[4:0] - 5'd1;
        prod_r <= {op_r[1], op_r[0]} * {wdat, op_r[4]};
      end else if (start_div) begin
        // short divide skips bytes 2 and 3
        st_r <= S_DIV;
        wide_r <= div_wide;
        if ({wdat, op_r[4]} == 16'h0000) begin
          ovf_r <= 1'b1;
          ovf_ev <= 1'b1;
        end
      end else if (start_shf) begin
        // control write starts normalise or shift
        st_r <= S_SHF;
        if (wdat[4:0] == 5'd0 && op_r[3][7]) begin
          ovf_r <= 1'b1;
          ovf_ev <= 1'b1;
        end
      end else if (!wr_op0) begin
        // a byte0 restart wins over a finishing operation's write-back
        case (st_r)
          S_MUL: begin
            mcnt_r <= mcnt_r - 5'd1;
            if (mcnt_r == 5'd1) begin
              {op_r[3], op_r[2], op_r[1], op_r[0]} <= prod_r;
              st_r <= S_DONE;
              done_ev <= 1'b1;
              if (prod_r[31:16] != 16'h0000) begin
                ovf_r <= 1'b1;
                ovf_ev <= 1'b1;
              end
            end
          end
          S_DIV: begin
            if (!div_busy) begin
              {op_r[3], op_r[2], op_r[1], op_r[0]} <= wide_r ? div_q : {16'h0000, div_q[15:0]};
              {op_r[5], op_r[4]} <= div_rem;
              st_r <= S_DONE;
              done_ev <= 1'b1;
            end
          end
          S_SHF: begin
            if (!shf_busy) begin
              {op_r[3], op_r[2], op_r[1], op_r[0]} <= shf_val;
              if (arc_r[4:0] == 5'd0) begin
                arc_r[4:0] <= shf_cnt;
              end
              st_r <= S_DONE;
              done_ev <= 1'b1;
            end
          end
          S_DONE: begin
            if (rd_arc) begin
              st_r <= S_IDLE;
              wmask_r <= 6'd0;
              mul_ord_r <= 1'b0;
            end
          end
          default: st_r <= S_IDLE;
        endcase
      end
    end
  end

  // =====================================================
  // interrupt status and mask
  reg [2:0] ist_r;
  reg [2:0] imsk_r;
  wire rd_ist = rd_now && rd_idx == `MDAC_IDX_IRQ_STAT;
  // irq lags the status by one edge so that it leaves a flop
  // a new event wins over the read clear
  always @(posedge core_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ist_r <= 3'd0;
      imsk_r <= 3'd0;
      irq_o <= 1'b0;
    end else begin
      ist_r <= (rd_ist ? 3'd0 : ist_r) | {ovf_ev, err_ev, done_ev};
      if (wr_pend_r && wr_idx_r == `MDAC_IDX_IRQ_MASK) begin
        imsk_r <= wdat[2:0];
      end
      irq_o <= |(ist_r & imsk_r);
    end
  end

  // =====================================================
  // read data, registered in the data phase
  always @(posedge core_clk_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      hrdata_o <= 32'h0000_0000;
    end else if (rd_now) begin
      case (rd_idx)
        `MDAC_IDX_OP0: hrdata_o <= {24'd0, op_r[0]};
        `MDAC_IDX_OP1: hrdata_o <= {24'd0, op_r[1]};
        `MDAC_IDX_OP2: hrdata_o <= {24'd0, op_r[2]};
        `MDAC_IDX_OP3: hrdata_o <= {24'd0, op_r[3]};
        `MDAC_IDX_OP4: hrdata_o <= {24'd0, op_r[4]};
        `MDAC_IDX_OP5: hrdata_o <= {24'd0, op_r[5]};
        `MDAC_IDX_ARC: hrdata_o <= {24'd0, err_r, ovf_r, arc_r[5:0]};
        `MDAC_IDX_IRQ_STAT: hrdata_o <= {29'd0, ist_r};
        `MDAC_IDX_IRQ_MASK: hrdata_o <= {29'd0, imsk_r};
        default: hrdata_o <= 32'h0000_0000;
      endcase
    end
  end
  // no done flag visible in control register
  wire [31:0] unused_addr = byte_addr(8'h00) | {29'd0, hsize_i};
endmodule
`default_nettype wire

// ### mdac_regs.vh
`ifndef MDAC_REGS_VH
`define MDAC_REGS_VH
// register indices; the bus byte address is the index times four
`define MDAC_IDX_OP0 8'hf9
`define MDAC_IDX_OP1 8'hfa
`define MDAC_IDX_OP2 8'hfb
`define MDAC_IDX_OP3 8'hfc
`define MDAC_IDX_OP4 8'hfd
`define MDAC_IDX_OP5 8'hfe
`define MDAC_IDX_ARC 8'hff
`define MDAC_IDX_IRQ_STAT 8'h40
`define MDAC_IDX_IRQ_MASK 8'h41
// arith_control field positions
`define MDAC_ARC_ERR 7
`define MDAC_ARC_OVF 6
`define MDAC_ARC_DIR 5
`define MDAC_ARC_RST 8'h00
// interrupt status bits
`define MDAC_IRQ_DONE 0
`define MDAC_IRQ_ERR 1
`define MDAC_IRQ_OVF 2
// divide latencies in cycles from the last load write; the multiply result lands at MDAC_LAT_MUL less one
`define MDAC_LAT_DIV32 17
`define MDAC_LAT_DIV16 9
`define MDAC_LAT_MUL 10
`define MDAC_LAT_SH_BASE 2
`endif

// ### mdac_divider.v
`default_nettype none
// =====================================================
// restoring divider, two quotient bits per cycle
module mdac_divider (
  // clock and reset
  input wire core_clk_i,
  input wire rst_n_i,
  // command
  input wire start_i,
  input wire wide_i,
  input wire [31:0] dividend_i,
  input wire [15:0] divisor_i,
  // result
  output reg busy_o,
  output reg [31:0] quot_o,
  output reg [15:0] rem_o
);
  reg [4:0] cnt_r;
  reg [16:0] part_r;
  reg [16:0] t1;
  reg [16:0] t2;
  reg q1;
  reg q2;
  reg [15:0] dvs_r; // divisor held for the whole run, the bus byte moves on
  // two restoring steps unrolled per clock
  always @* begin
    t1 = {part_r[15:0], quot_o[31]};
    q1 = (t1 >= {1'b0, dvs_r});
    if (q1) begin
      t1 = t1 - {1'b0, dvs_r};
    end
    t2 = {t1[15:0], quot_o[30]};
    q2 = (t2 >= {1'b0, dvs_r});
    if (q2) begin
      t2 = t2 - {1'b0, dvs_r};
    end
  end
  // sixteen cycles for a 32-bit dividend, eight for 16-bit
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
      cnt_r <= 5'd0;
      dvs_r <= 16'h0000;
      part_r <= 17'd0;
      quot_o <= 32'h0000_0000;
      rem_o <= 16'h0000;
    end else if (start_i) begin
      busy_o <= 1'b1;
      part_r <= 17'd0;
      dvs_r <= divisor_i;
      cnt_r <= wide_i ? 5'd16 : 5'd8;
      quot_o <= wide_i ? dividend_i : {dividend_i[15:0], 16'h0000};
    end else if (busy_o) begin
      part_r <= t2;
      quot_o <= {quot_o[29:0], q1, q2};
      cnt_r <= cnt_r - 5'd1;
      if (cnt_r == 5'd1) begin
        busy_o <= 1'b0;
        rem_o <= t2[15:0];
      end
    end
  end
endmodule
`default_nettype wire

// ### mdac_shifter.v
`default_nettype none
// =====================================================
// one-bit-per-cycle shifter and normaliser
module mdac_shifter (
  // clock and reset
  input wire core_clk_i,
  input wire rst_n_i,
  // command
  input wire start_i,
  input wire norm_i,
  input wire right_i,
  input wire [4:0] count_i,
  input wire [31:0] value_i,
  // result
  output reg busy_o,
  output reg [31:0] value_o,
  output reg [4:0] shifts_o
);
  reg [4:0] left_r;
  reg norm_r; // mode and direction held for the run, the bus byte moves on
  reg right_r;
  // normalise stops at the first one in bit 31, at a zero value or at 31 shifts
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
      value_o <= 32'h0000_0000;
      shifts_o <= 5'd0;
      left_r <= 5'd0;
      norm_r <= 1'b0;
      right_r <= 1'b0;
    end else if (start_i) begin
      busy_o <= 1'b1;
      value_o <= value_i;
      shifts_o <= 5'd0;
      left_r <= count_i;
      norm_r <= norm_i;
      right_r <= right_i;
    end else if (busy_o) begin
      if (norm_r) begin
        if (value_o[31] || value_o == 32'h0000_0000 || shifts_o == 5'd31) begin
          busy_o <= 1'b0;
        end else begin
          value_o <= {value_o[30:0], 1'b0};
          shifts_o <= shifts_o + 5'd1;
        end
      end else if (left_r == 5'd0) begin
        busy_o <= 1'b0;
      end else begin
        value_o <= right_r ? {1'b0, value_o[31:1]} : {value_o[30:0], 1'b0};
        left_r <= left_r - 5'd1;
      end
    end
  end
endmodule
`default_nettype wire

// ### mdac_accel_checker.sv
`include "mdac_regs.vh"
`default_nettype none
// ==========================================
// port-level checks on the accelerator's bus face
module mdac_accel_checker #(
  parameter integer LAT_MUL = 10
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // bus side
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic irq_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);
  // transfers taken at this edge
  wire rd_t = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
  wire wr_t = hsel_i && hready_i && htrans_i[1] && hwrite_i;
  reg [1:0] rel_cnt;
  reg wr_seen;
  // edges since release; the internal reset copy lags two edges, so ready is owed from the third
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rel_cnt <= 2'h0;
      wr_seen <= 1'b0;
    end else begin
      if (rel_cnt != 2'h3) rel_cnt <= rel_cnt + 2'h1;
      if (wr_t) wr_seen <= 1'b1;
    end
  end
  sequence ctrl_rd;
    rd_t && haddr_i == {22'h0, `MDAC_IDX_ARC, 2'h0};
  endsequence
  sequence mask_clr;
    wr_t && haddr_i == {22'h0, `MDAC_IDX_IRQ_MASK, 2'h0} ##1 hwdata_i[2:0] == 3'h0;
  endsequence
  resp_okay_a: // bus response
    assert property (hresp_o == 1'b0) else $error("response not OKAY");
  ready_up_a: // zero wait after reset
    assert property (rel_cnt == 2'h3 |-> hreadyout_o) else $error("ready low after reset");
  upper_zero_a: // byte registers
    assert property (rd_t |=> hrdata_o[31:8] == 24'h0) else $error("upper read bits set");
  unmapped_a: // refused places
    assert property (rd_t && (haddr_i[1:0] != 2'h0 || haddr_i[31:10] != 22'h0) |=> hrdata_o == 32'h0)
      else $error("unmapped read not zero");
  rdata_hold_a: // read data stands
    assert property (!rd_t |=> $stable(hrdata_o)) else $error("read data moved");
  reset_vals_a: // reset values
    assert property (rd_t && !wr_seen |=> hrdata_o == 32'h0) else $error("reset value not zero");
  err_clear_a:
    assert property (ctrl_rd ##1 !wr_t ##1 ctrl_rd |=> !hrdata_o[7]) else $error("error flag survived read");
  irq_quiet_a: // masked interrupt
    assert property (mask_clr |-> ##3 !irq_o [*4]) else $error("irq high with mask clear");
endmodule
bind mdac_muldiv_accel mdac_accel_checker #(.LAT_MUL(LAT_MUL)) mdac_accel_checker_inst (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
  .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
  .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
  .irq_o(irq_o));
`default_nettype wire

// ### mdac_cpu_model.sv
`default_nettype none
// ==========================================
// cpu-side bus master, single word transfers
module mdac_cpu_model (
  // clock and answer
  input wire logic core_clk_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_i,
  // request
  output var logic [1:0] htrans_o = 2'h0,
  output var logic [31:0] haddr_o = 32'h0,
  output var logic hwrite_o = 1'b0,
  output var logic [31:0] hwdata_o = 32'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  // entered just after an edge, returns at the edge ending the data phase
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    htrans_o <= 2'h2;
    haddr_o <= a;
    hwrite_o <= w;
    @(posedge core_clk_i);
    while (hready_i !== 1'b1) @(posedge core_clk_i);
    // released lines flip so a stale value never passes for a live one
    htrans_o <= 2'h0;
    haddr_o <= ~a;
    hwdata_o <= w ? d : ~hwdata_o;
    @(posedge core_clk_i);
    while (hready_i !== 1'b1) @(posedge core_clk_i);
    q = hrdata_i;
    hwdata_o <= ~hwdata_o;
  endtask
endmodule
`default_nettype wire

// ### tb.sv
`include "mdac_regs.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] OP0 = `MDAC_IDX_OP0;
  localparam logic [7:0] ARC = `MDAC_IDX_ARC;
  localparam logic [7:0] STA = `MDAC_IDX_IRQ_STAT;
  localparam logic [7:0] MSK = `MDAC_IDX_IRQ_MASK;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [31:0] seed = 32'h0000_509f;
  logic [31:0] q, r, v, e;
  logic [47:0] res;
  logic [15:0] a, b, ds;
  logic [4:0] sc;
  logic wide, dir;
  int err_count = 0;
  int n_compared = 0;
  wire [1:0] htrans;
  wire [31:0] haddr, hwdata, hrdata;
  wire hwrite, hreadyout, hresp, irq;
  always #50 core_clk = ~core_clk;
  mdac_muldiv_accel #(.LAT_MUL(10)) mdac_muldiv_accel_inst (
    .core_clk_i(core_clk), .resetn_i(resetn), .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata),
    .hreadyout_o(hreadyout), .hresp_o(hresp), .irq_o(irq));
  mdac_cpu_model mdac_cpu_model_inst (
    .core_clk_i(core_clk), .hready_i(hreadyout), .hrdata_i(hrdata), .htrans_o(htrans),
    .haddr_o(haddr), .hwrite_o(hwrite), .hwdata_o(hwdata));
  // ==========================================
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [4:0] lz(input logic [31:0] x);
    lz = 5'h00;
    for (int i = 31; i > 0 && !x[i]; i--) lz = lz + 5'h01;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    mdac_cpu_model_inst.xfer(1'b1, {22'h0, idx, 2'h0}, {24'h0, d}, q);
  endtask
  task automatic rd(input logic [7:0] idx);
    mdac_cpu_model_inst.xfer(1'b0, {22'h0, idx, 2'h0}, 32'h0, q);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [31:0] x);
    rd(idx);
    chk(q, x);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================
  // watchdog, about twenty-five times the expected run
  initial begin
    #2_000_000;
    err_count++;
    end_of_test();
  end
  // ==========================================
  // main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    resetn <= 1'b1;
    // the internal reset copy lags two edges; a request before that is lost
    idle(3);
    for (int i = 0; i < 7; i++) rdc(OP0 + 8'(i), 32'h0);
    // unmapped place ignores the write and reads zero
    mdac_cpu_model_inst.xfer(1'b1, 32'h0000_0400, 32'h0000_00a5, q);
    mdac_cpu_model_inst.xfer(1'b0, 32'h0000_0400, 32'h0, q);
    chk(q, 32'h0);
    // multiplies: all ones, a small one, then random
    for (int k = 0; k < 6; k++) begin
      r = xs();
      {a, b} = (k == 0) ? 32'hffff_ffff : (k == 1) ? {8'h0, r[7:0], 8'h0, r[15:8]} : r;
      wr(OP0, a[7:0]);
      wr(OP0 + 8'h04, b[7:0]);
      wr(OP0 + 8'h01, a[15:8]);
      wr(OP0 + 8'h05, b[15:8]);
      idle(10);
      res = a * b;
      for (int i = 0; i < 4; i++) rdc(OP0 + 8'(i), {24'h0, res[8*i +: 8]});
      rd(ARC);
      chk({30'h0, q[7:6]}, {31'h0, res > 48'h0000_ffff});
    end
    // divides of both widths; the third has a zero divisor
    for (int k = 0; k < 6; k++) begin
      wide = k[0];
      r = xs();
      v = xs();
      if (!wide) r[31:16] = 16'h0;
      ds = (k == 2) ? 16'h0 : v[15:0];
      wr(OP0, r[7:0]);
      wr(OP0 + 8'h01, r[15:8]);
      if (wide) wr(OP0 + 8'h02, r[23:16]);
      if (wide) wr(OP0 + 8'h03, r[31:24]);
      wr(OP0 + 8'h04, ds[7:0]);
      wr(OP0 + 8'h05, ds[15:8]);
      idle(wide ? `MDAC_LAT_DIV32 : `MDAC_LAT_DIV16);
      res[31:0] = r / ds;
      res[47:32] = r % ds;
      for (int i = 0; i < 6; i++) begin
        if (wide || i < 2 || i > 3) begin
          rd(OP0 + 8'(i));
          if (ds != 16'h0) chk(q, {24'h0, res[8*i +: 8]});
        end
      end
      rd(ARC);
      chk({30'h0, q[7:6]}, {31'h0, ds == 16'h0});
    end
    // normalise (leading zeros 0, 8, 16), then shifts of both directions
    for (int k = 0; k < 8; k++) begin
      r = xs();
      dir = (k == 3) || (k > 4 && r[5]);
      sc = (k < 3) ? 5'h00 : (k == 3) ? 5'h10 : {1'b0, r[3:0]} + 5'h01;
      v = (k < 3) ? ((r | 32'h8000_0000) >> (k * 8)) : xs();
      // operand then control write starts it
      for (int i = 0; i < 4; i++) wr(OP0 + 8'(i), v[8*i +: 8]);
      wr(ARC, {2'h0, dir, sc});
      idle(k < 3 ? 20 : 18);
      e = (k < 3) ? v << lz(v) : dir ? v >> sc : v << sc;
      for (int i = 0; i < 4; i++) rdc(OP0 + 8'(i), {24'h0, e[8*i +: 8]});
      rd(ARC);
      if (k < 3) chk(q, {24'h0, 1'b0, v[31], 1'b0, lz(v)});
      else chk({30'h0, q[7:6]}, 32'h0);
    end
    // a multiply cut short by a fresh byte-0 write, then run as 100 / 7
    wr(OP0, 8'h34);
    wr(OP0 + 8'h04, 8'h07);
    wr(OP0 + 8'h01, 8'h12);
    wr(OP0 + 8'h05, 8'h00);
    wr(OP0, 8'h64);
    wr(OP0 + 8'h01, 8'h00);
    wr(OP0 + 8'h04, 8'h07);
    wr(OP0 + 8'h05, 8'h00);
    idle(`MDAC_LAT_DIV16);
    rdc(OP0, 32'h0000_000e);
    rdc(OP0 + 8'h01, 32'h0);
    rdc(OP0 + 8'h04, 32'h0000_0002);
    rdc(OP0 + 8'h05, 32'h0);
    rd(ARC);
    chk({31'h0, q[7]}, 32'h0000_0001);
    rd(ARC);
    chk({31'h0, q[7]}, 32'h0);
    // pending events stay hidden while masked, then show until a status read
    chk({31'h0, irq}, 32'h0);
    wr(MSK, 8'h07);
    idle(3);
    chk({31'h0, irq}, 32'h0000_0001);
    rd(STA);
    chk({31'h0, q[1]}, 32'h0000_0001);
    rdc(STA, 32'h0);
    idle(3);
    chk({31'h0, irq}, 32'h0);
    wr(MSK, 8'h00);
    idle(6);
    end_of_test();
  end
endmodule
`default_nettype wire
